// ### rtl/tpg_pkg.sv
// Package with constants shared by the serial test pattern and power-down block.
package tpg_pkg;

  // Register byte addresses on the Avalon-MM slave (word index = byte address / 4).
  localparam logic [3:0] OFS_CTRL   = 4'h0;  // Test select and soft power-down.
  localparam logic [3:0] OFS_LINK   = 4'h4;  // Link mode and coding choice.
  localparam logic [3:0] OFS_CHAN   = 4'h8;  // Channel pair enables.
  localparam logic [3:0] OFS_STATUS = 4'hc;  // Read-only block state.

  // Field positions and reset values.
  localparam int         CTRL_SEL_LSB = 0;        // Test select field, 4 bits.
  localparam int         CTRL_PD_BIT  = 4;        // Soft power-down bit.
  localparam int         LINK_MODE_LSB = 0;       // Link mode field, 5 bits.
  localparam int         LINK_CODE_BIT = 5;       // 1 selects 64B/66B, 0 selects 8B/10B.
  localparam logic [1:0] CHAN_RESET   = 2'h3;     // Both channel pairs powered.

  // Test pattern selections.
  typedef enum logic [3:0] {
    SEL_OFF   = 4'h0,
    SEL_PRBS7 = 4'h1,
    SEL_PRBS9 = 4'h2,
    SEL_PRBS15 = 4'h3,
    SEL_PRBS23 = 4'h4,
    SEL_PRBS31 = 4'h5,
    SEL_CLOCK = 4'h6,
    SEL_RAMP  = 4'h7,
    SEL_SHORT = 4'h8
  } test_sel_e;

  // Lane geometry.
  localparam int          NUM_LANES  = 8;
  localparam int          OCTET_W    = 8;
  localparam int          PRBS_W     = 31;
  localparam logic [30:0] PRBS_SEED  = 31'h0000_0001;  // Per-lane seed base.

  // Clock pattern halves and ramp start value.
  localparam logic [7:0] CLK_ONES   = 8'hff;
  localparam logic [7:0] CLK_ZEROS  = 8'h00;
  localparam logic [7:0] RAMP_START = 8'h00;

  // Short transport frame lengths in octets, each stored as the last octet index.
  localparam logic [2:0] FRAME_LEN_M0 = 3'h7;  // Last octet index, eight octets.
  localparam logic [2:0] FRAME_LEN_M2 = 3'h0;  // One octet.
  localparam logic [2:0] FRAME_LEN_M3 = 3'h5;  // Six octets.
  localparam logic [3:0] TAIL_NIBBLE  = 4'h0;  // Filler nibble closing a mode 0 frame.

  // Link modes with known short patterns and their powered lane counts.
  localparam logic [4:0] LMODE_0 = 5'h00;
  localparam logic [4:0] LMODE_1 = 5'h01;
  localparam logic [4:0] LMODE_2 = 5'h02;
  localparam logic [4:0] LMODE_3 = 5'h03;
  localparam logic [3:0] LANES_M0 = 4'h8;
  localparam logic [3:0] LANES_M1 = 4'h6;
  localparam logic [3:0] LANES_M23 = 4'h4;

endpackage

// ### rtl/serdes_test_pattern_and_powerdown.sv
// Lane test pattern generator and power-down control with an Avalon-MM register slave.
// Overview of operation
// - Power-down pin high turns off lane drivers.
// - Configuration survives any power-down period.
// - Channels power down in pairs only.
// - Select picks pattern; link mode sets lanes.
// - PRBS bypasses transport and link layers.
// - PRBS7 taps six and seven, length 127.
// - PRBS9 taps five and nine, length 511.
// - PRBS15 taps fourteen and fifteen.
// - PRBS23 taps eighteen and twenty-three.
// - PRBS31 taps twenty-eight and thirty-one.
// - Each lane starts PRBS at distinct phase.
// - Clock pattern: eight ones, eight zeros, bypassed.
// - Ramp: link layer on, transport off.
// - Ramp starts after link initialisation completes.
// - Ramp octets 0x00 to 0xFF on all lanes.
// - Short transport frame repeats every frame.
// - No long transport pattern is offered.
// - Link mode 0 words per lane pattern.
// - Link mode 2 single octet per lane.
// - Link mode 3 four words per lane.
//
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps

module serdes_test_pattern_and_powerdown (
  input  wire logic        CLK,              // 250 MHz clock.
  input  wire logic        RESETN,           // Asynchronous active-low reset.
  input  wire logic        POWER_DOWN_PIN,   // Power-down pin, asynchronous.
  input  wire logic        LINK_INIT_DONE,   // ILA or serializer init finished, same clock.
  input  wire logic [63:0] SAMPLE_DATA,      // Normal transport octets, lane k at [8k+7:8k].
  input  wire logic [3:0]  AVS_ADDRESS,      // Byte address.
  input  wire logic        AVS_READ,         // Read request.
  input  wire logic        AVS_WRITE,        // Write request.
  input  wire logic [31:0] AVS_WRITEDATA,    // Write data.
  input  wire logic [3:0]  AVS_BYTEENABLE,   // Byte enables.
  output logic      [31:0] AVS_READDATA,     // Read data.
  output logic             AVS_WAITREQUEST,  // Stall.
  output logic      [63:0] LANE_DATA,        // Lane octets, lane k at [8k+7:8k].
  output logic      [7:0]  LANE_ENABLE,      // Lane driver enables.
  output logic             LINK_BYPASS,      // Skip scrambling and line coding.
  output logic             TRANSPORT_OFF     // Transport layer output ignored.
);

  // Reset release synchroniser; all logic uses the synchronised copy.
  logic rst_s1_r, rst_n_r;
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // Power-down pin passes three flops; a change counts once the last two agree.
  logic pd_s1_r, pd_s2_r, pd_s3_r, pd_pin_r;
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pd_s1_r  <= 1'b0;
      pd_s2_r  <= 1'b0;
      pd_s3_r  <= 1'b0;
      pd_pin_r <= 1'b0;
    end else begin
      pd_s1_r <= POWER_DOWN_PIN;
      pd_s2_r <= pd_s1_r;
      pd_s3_r <= pd_s2_r;
      if (pd_s2_r == pd_s3_r) begin
        pd_pin_r <= pd_s3_r;
      end
    end
  end

  // Avalon handshake: the first cycle of a request stalls, the second completes it.
  logic bus_req, ack_r;
  assign bus_req         = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = bus_req & ~ack_r;
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_req & ~ack_r;
    end
  end

  // Software registers.
  logic [3:0] test_pattern_select_r;   // Active test pattern.
  logic       soft_pd_r;               // Software power-down.
  logic [4:0] link_mode_select_r;      // Link mode.
  logic       code_64b_r;              // Coding choice.
  logic [1:0] channel_pair_enable_r;   // Channel pair power.
  logic       wr_en;
  assign wr_en = AVS_WRITE & ack_r;

  // kept through power-down
  // Only reset clears these; power-down never touches them, so setup survives it.
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      test_pattern_select_r <= tpg_pkg::SEL_OFF;
      soft_pd_r             <= 1'b0;
      link_mode_select_r    <= tpg_pkg::LMODE_0;
      code_64b_r            <= 1'b0;
      channel_pair_enable_r <= tpg_pkg::CHAN_RESET;
    end else if (wr_en && AVS_BYTEENABLE[0]) begin
      case (AVS_ADDRESS)
        tpg_pkg::OFS_CTRL: begin
          test_pattern_select_r <= AVS_WRITEDATA[tpg_pkg::CTRL_SEL_LSB +: 4];
          soft_pd_r             <= AVS_WRITEDATA[tpg_pkg::CTRL_PD_BIT];
        end
        tpg_pkg::OFS_LINK: begin
          link_mode_select_r <= AVS_WRITEDATA[tpg_pkg::LINK_MODE_LSB +: 5];
          code_64b_r         <= AVS_WRITEDATA[tpg_pkg::LINK_CODE_BIT];
        end
        tpg_pkg::OFS_CHAN: begin
          channel_pair_enable_r <= AVS_WRITEDATA[1:0];
        end
        default: begin
          // Unmapped writes are ignored.
        end
      endcase
    end
  end

  // Combined power-down and status state.
  logic       powered_down;
  logic       ramp_run_r;
  logic [7:0] lane_on;
  assign powered_down = pd_pin_r | soft_pd_r;

  // Read data is loaded in the stall cycle and stands at the completing edge.
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (AVS_READ && !ack_r) begin
      case (AVS_ADDRESS)
        tpg_pkg::OFS_CTRL:   AVS_READDATA <= {27'h0, soft_pd_r, test_pattern_select_r};
        tpg_pkg::OFS_LINK:   AVS_READDATA <= {26'h0, code_64b_r, link_mode_select_r};
        tpg_pkg::OFS_CHAN:   AVS_READDATA <= {30'h0, channel_pair_enable_r};
        tpg_pkg::OFS_STATUS: AVS_READDATA <= {22'h0, lane_on, ramp_run_r, powered_down};
        default:             AVS_READDATA <= 32'h0000_0000;
      endcase
    end
  end

  // Powered lanes for a link mode; the test selection has no say in this.
  function automatic logic [3:0] lanes_for_mode(input logic [4:0] mode);
    case (mode)
      tpg_pkg::LMODE_0: lanes_for_mode = tpg_pkg::LANES_M0;
      tpg_pkg::LMODE_1: lanes_for_mode = tpg_pkg::LANES_M1;
      tpg_pkg::LMODE_2: lanes_for_mode = tpg_pkg::LANES_M23;
      tpg_pkg::LMODE_3: lanes_for_mode = tpg_pkg::LANES_M23;
      default:          lanes_for_mode = tpg_pkg::LANES_M0;
    endcase
  endfunction

  // drivers off in power-down
  // Lanes 0-3 belong to the first channel pair, lanes 4-7 to the second.
  always_comb begin
    for (int k = 0; k < tpg_pkg::NUM_LANES; k++) begin
      lane_on[k] = (4'(k) < lanes_for_mode(link_mode_select_r)) &&
                   channel_pair_enable_r[k / 4] && !powered_down;
    end
  end
  assign LANE_ENABLE = lane_on;

  // One PRBS step: new bit is the XOR of the two tapped earlier bits, state[0] newest.
  function automatic logic [30:0] prbs_step(input logic [30:0] s, input logic [3:0] sel);
    logic b;
    b = 1'b0;
    case (sel)
      tpg_pkg::SEL_PRBS7:  b = s[5] ^ s[6];
      tpg_pkg::SEL_PRBS9:  b = s[4] ^ s[8];
      tpg_pkg::SEL_PRBS15: b = s[13] ^ s[14];
      tpg_pkg::SEL_PRBS23: b = s[17] ^ s[22];
      tpg_pkg::SEL_PRBS31: b = s[27] ^ s[30];
      default:             b = 1'b0;
    endcase
    prbs_step = {s[29:0], b};
  endfunction

  function automatic logic is_prbs(input logic [3:0] sel);
    is_prbs = (sel >= tpg_pkg::SEL_PRBS7) && (sel <= tpg_pkg::SEL_PRBS31);
  endfunction

  // Selection seen last cycle, used to reseed generators on any change.
  logic [3:0] sel_prev_r;
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sel_prev_r <= tpg_pkg::SEL_OFF;
    end else begin
      sel_prev_r <= test_pattern_select_r;
    end
  end

  // Per-lane PRBS state; eight bit steps per clock give one octet, first bit in the MSB.
  logic [30:0] prbs_r [tpg_pkg::NUM_LANES];
  logic [7:0]  prbs_oct [tpg_pkg::NUM_LANES];
  logic [30:0] prbs_nxt [tpg_pkg::NUM_LANES];
  always_comb begin
    for (int k = 0; k < tpg_pkg::NUM_LANES; k++) begin
      prbs_nxt[k] = prbs_r[k];
      prbs_oct[k] = 8'h00;
      for (int i = 0; i < tpg_pkg::OCTET_W; i++) begin
        prbs_nxt[k]     = prbs_step(prbs_nxt[k], test_pattern_select_r);
        prbs_oct[k][7 - i] = prbs_nxt[k][0];
      end
    end
  end

  // distinct lane phase
  // Lane k starts from the seed plus k. Small distinct seeds differ even in the seven
  // low stages, so no two lanes run in step in any mode, not even the shortest one.
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      for (int k = 0; k < tpg_pkg::NUM_LANES; k++) begin
        prbs_r[k] <= tpg_pkg::PRBS_SEED;
      end
    end else begin
      for (int k = 0; k < tpg_pkg::NUM_LANES; k++) begin
        if (test_pattern_select_r != sel_prev_r) begin
          prbs_r[k] <= tpg_pkg::PRBS_SEED + 31'(k);
        end else begin
          prbs_r[k] <= prbs_nxt[k];
        end
      end
    end
  end

  // clock pattern halves
  // Octet phase toggles every clock, giving eight ones then eight zeros.
  logic clk_phase_r;
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      clk_phase_r <= 1'b0;
    end else begin
      clk_phase_r <= ~clk_phase_r;
    end
  end

  // ramp waits for init
  // The ramp is held at its start until link initialisation reports done.
  // ramp 0x00 to 0xFF
  logic [7:0] ramp_r;
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ramp_run_r <= 1'b0;
      ramp_r     <= tpg_pkg::RAMP_START;
    end else if (test_pattern_select_r != tpg_pkg::SEL_RAMP || !LINK_INIT_DONE) begin
      ramp_run_r <= 1'b0;
      ramp_r     <= tpg_pkg::RAMP_START;
    end else begin
      ramp_run_r <= 1'b1;
      ramp_r     <= ramp_run_r ? ramp_r + 8'h01 : tpg_pkg::RAMP_START;
    end
  end

  // Frame length in octets minus one, per link mode.
  function automatic logic [2:0] frame_last(input logic [4:0] mode);
    case (mode)
      tpg_pkg::LMODE_2: frame_last = tpg_pkg::FRAME_LEN_M2;
      tpg_pkg::LMODE_3: frame_last = tpg_pkg::FRAME_LEN_M3;
      default:          frame_last = tpg_pkg::FRAME_LEN_M0;
    endcase
  endfunction

  // Whole short transport frame for one lane, first octet in the top byte.
  function automatic logic [63:0] short_frame(input logic [4:0] mode, input int lane);
    logic [3:0] ln;
    logic [3:0] up;
    ln = 4'(lane);
    up = 4'hf - ln;
    case (mode)
      tpg_pkg::LMODE_2: short_frame = {ln, 4'h1, 56'h0};
      // four words, upper 3 down to 0
      tpg_pkg::LMODE_3: short_frame = {4'h3 - ln, ln, 4'h1, 4'h3 - ln, ln, 4'h2,
                                       4'h3 - ln, ln, 4'h3, 4'h3 - ln, ln, 4'h4, 16'h0};
      // mode 1 uses the nibble scheme
      default: short_frame = {up, ln, 4'h1, up, ln, 4'h2, up, ln, 4'h3,
                              up, ln, 4'h4, up, ln, 4'h5, tpg_pkg::TAIL_NIBBLE};
    endcase
  endfunction

  // frame repeats
  // Octet index within the frame wraps at the mode's frame length.
  logic [2:0] oct_idx_r;
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      oct_idx_r <= 3'h0;
    end else if (test_pattern_select_r != tpg_pkg::SEL_SHORT ||
                 oct_idx_r >= frame_last(link_mode_select_r)) begin
      oct_idx_r <= 3'h0;
    end else begin
      oct_idx_r <= oct_idx_r + 3'h1;
    end
  end

  // Short frame octet of every lane at the current index, kept out of the clocked mux.
  logic [63:0] frame_v   [tpg_pkg::NUM_LANES];  // Whole frame per lane.
  logic [7:0]  short_oct [tpg_pkg::NUM_LANES];  // Current frame octet per lane.
  always_comb begin
    for (int k = 0; k < tpg_pkg::NUM_LANES; k++) begin
      frame_v[k]   = short_frame(link_mode_select_r, k);
      short_oct[k] = frame_v[k][63 - 8*oct_idx_r -: 8];
    end
  end

  // Lane data mux; registered so lane octets always come from flops.
  // no long transport pattern
  // Unused selections, including any long transport request, send normal data.
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      LANE_DATA <= 64'h0;
    end else begin
      for (int k = 0; k < tpg_pkg::NUM_LANES; k++) begin
        case (test_pattern_select_r)
          tpg_pkg::SEL_PRBS7, tpg_pkg::SEL_PRBS9, tpg_pkg::SEL_PRBS15,
          tpg_pkg::SEL_PRBS23, tpg_pkg::SEL_PRBS31:
            LANE_DATA[8*k +: 8] <= prbs_oct[k];
          tpg_pkg::SEL_CLOCK:
            LANE_DATA[8*k +: 8] <= clk_phase_r ? tpg_pkg::CLK_ZEROS : tpg_pkg::CLK_ONES;
          tpg_pkg::SEL_RAMP:
            LANE_DATA[8*k +: 8] <= ramp_r;
          tpg_pkg::SEL_SHORT:
            LANE_DATA[8*k +: 8] <= short_oct[k];
          default:
            LANE_DATA[8*k +: 8] <= SAMPLE_DATA[8*k +: 8];
        endcase
      end
    end
  end

  // PRBS skips link layer
  // Clock and PRBS patterns go straight to the serializers; ramp keeps the link layer.
  // ramp disables transport
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      LINK_BYPASS   <= 1'b0;
      TRANSPORT_OFF <= 1'b0;
    end else begin
      LINK_BYPASS   <= is_prbs(test_pattern_select_r) ||
                       test_pattern_select_r == tpg_pkg::SEL_CLOCK;
      TRANSPORT_OFF <= test_pattern_select_r != tpg_pkg::SEL_OFF;
    end
  end

  // Checks kept next to the logic they guard.
  chk_pd_lanes_off: assert property (@(posedge CLK) disable iff (!rst_n_r)
    pd_pin_r |-> LANE_ENABLE == 8'h00) else $error("lanes driven in power-down");

  chk_cfg_kept_pd: assert property (@(posedge CLK) disable iff (!rst_n_r)
    (powered_down && !wr_en) |=> $stable(link_mode_select_r) && $stable(test_pattern_select_r))
    else $error("configuration changed during power-down");

  chk_pair_gate: assert property (@(posedge CLK) disable iff (!rst_n_r)
    !channel_pair_enable_r[1] |-> LANE_ENABLE[7:4] == 4'h0) else $error("pair not gated");

  chk_mode_lanes: assert property (@(posedge CLK) disable iff (!rst_n_r)
    (link_mode_select_r == tpg_pkg::LMODE_2) |-> LANE_ENABLE[7:4] == 4'h0)
    else $error("lane count not from link mode");

  chk_prbs_bypass: assert property (@(posedge CLK) disable iff (!rst_n_r)
    is_prbs(test_pattern_select_r) |=> LINK_BYPASS) else $error("prbs not bypassed");

  chk_prbs7_rec: assert property (@(posedge CLK) disable iff (!rst_n_r)
    (test_pattern_select_r == tpg_pkg::SEL_PRBS7 && $stable(test_pattern_select_r))
      |-> prbs_nxt[0][0] == (prbs_nxt[0][6] ^ prbs_nxt[0][7]))
    else $error("prbs7 recursion broken");

  chk_prbs31_rec: assert property (@(posedge CLK) disable iff (!rst_n_r)
    (test_pattern_select_r == tpg_pkg::SEL_PRBS31 && $stable(test_pattern_select_r))
      |-> prbs_nxt[1][7] == (prbs_r[1][27] ^ prbs_r[1][30]))
    else $error("prbs31 recursion broken");

  chk_clock_pat: assert property (@(posedge CLK) disable iff (!rst_n_r)
    (test_pattern_select_r == tpg_pkg::SEL_CLOCK)[*3]
      |-> LANE_DATA[7:0] != $past(LANE_DATA[7:0])) else $error("clock pattern stuck");

  chk_ramp_step: assert property (@(posedge CLK) disable iff (!rst_n_r)
    (ramp_run_r && $past(ramp_run_r)) |-> ramp_r == $past(ramp_r) + 8'h01)
    else $error("ramp did not step");

  chk_ramp_wait: assert property (@(posedge CLK) disable iff (!rst_n_r)
    !LINK_INIT_DONE |=> !ramp_run_r) else $error("ramp ran before init");

endmodule

// ### dv/lane_rx_model.sv
// Receiver model that self-synchronises to one lane's PRBS stream and checks its recurrence.
`timescale 1ns/1ps
module lane_rx_model #(
  parameter int FLUSH = 4  // Octets dropped after the lane comes back.
) (
  input  wire logic       clk,       // Octet clock.
  input  wire logic       rst_n,     // Active-low reset.
  input  wire logic [7:0] octet,     // Lane octet, earliest bit in the MSB.
  input  wire logic       lane_on,   // Lane driver enable.
  input  wire logic [4:0] tap_a,     // Nearer recurrence tap.
  input  wire logic [4:0] tap_b,     // Farther recurrence tap.
  input  wire logic       check_en,  // Checking armed by the bench.
  output logic     [15:0] bad_bits,  // Bits that broke the recurrence.
  output logic     [15:0] good_bits  // Bits that kept the recurrence.
);
  logic [31:0] hist;   // Recent bits, the newest in bit 0.
  int          seen;   // Bits gathered since the last restart.
  int          flush;  // Octets still to discard.
  logic        b;      // Bit under test.

  // The start phase is unknown, so the first tap_b bits only fill the history.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seen      = 0;
      flush     = FLUSH;
      bad_bits  = 16'h0;
      good_bits = 16'h0;
      hist      = 32'h0;
    end else if (!lane_on || !check_en) begin
      seen  = 0;
      flush = FLUSH;
    end else if (flush != 0) begin
      flush = flush - 1;
    end else begin
      for (int i = 7; i >= 0; i--) begin
        b = octet[i];
        if (seen < tap_b) begin
          seen = seen + 1;
        end else if (b === (hist[tap_a - 5'd1] ^ hist[tap_b - 5'd1])) begin
          good_bits = good_bits + 16'h1;
        end else begin
          bad_bits = bad_bits + 16'h1;
        end
        hist = {hist[30:0], b};
      end
    end
  end
endmodule

// ### dv/tb_top.sv
// Self-checking bench for the lane test pattern and power-down block.
`timescale 1ns/1ps
module tb_top;
  logic        CLK            = 1'b0;   // 250 MHz clock.
  logic        RESETN         = 1'b0;   // Active-low reset.
  logic        POWER_DOWN_PIN = 1'b0;   // Power-down pin.
  logic        LINK_INIT_DONE = 1'b0;   // Link start-up finished.
  logic [63:0] SAMPLE_DATA    = 64'h0;  // Normal transport octets.
  logic [3:0]  AVS_ADDRESS    = 4'h0;   // Register byte address.
  logic        AVS_READ       = 1'b0;   // Read request.
  logic        AVS_WRITE      = 1'b0;   // Write request.
  logic [31:0] AVS_WRITEDATA  = 32'h0;  // Write data.
  logic [3:0]  AVS_BYTEENABLE = 4'hf;   // Byte enables.
  logic [31:0] AVS_READDATA;            // Read data.
  logic        AVS_WAITREQUEST;         // Slave stall.
  logic [63:0] LANE_DATA;               // Lane octets.
  logic [7:0]  LANE_ENABLE;             // Lane driver enables.
  logic        LINK_BYPASS;             // Scrambling and coding skipped.
  logic        TRANSPORT_OFF;           // Transport output ignored.
  logic        check_en       = 1'b0;   // Receiver checking armed.
  logic [4:0]  tap_a          = 5'h6;   // Nearer tap.
  logic [4:0]  tap_b          = 5'h7;   // Farther tap.
  logic [15:0] bad_bits;                // Receiver failures.
  logic [15:0] good_bits;               // Receiver passes.
  logic [31:0] rd;                      // Last read word.
  int          errors         = 0;      // Mismatch count.
  int          n_tests        = 0;      // Comparison count.

  // The clock inverts every half period.
  always #2 CLK = ~CLK;

  serdes_test_pattern_and_powerdown serdes_test_pattern_and_powerdown_i (
    .CLK(CLK), .RESETN(RESETN), .POWER_DOWN_PIN(POWER_DOWN_PIN),
    .LINK_INIT_DONE(LINK_INIT_DONE), .SAMPLE_DATA(SAMPLE_DATA), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .LANE_DATA(LANE_DATA), .LANE_ENABLE(LANE_ENABLE),
    .LINK_BYPASS(LINK_BYPASS), .TRANSPORT_OFF(TRANSPORT_OFF));

  lane_rx_model lane_rx_model_i (
    .clk(CLK), .rst_n(RESETN), .octet(LANE_DATA[7:0]), .lane_on(LANE_ENABLE[0]),
    .tap_a(tap_a), .tap_b(tap_b), .check_en(check_en), .bad_bits(bad_bits),
    .good_bits(good_bits));

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d.", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // A wait that ran out of cycles ends the run at once.
  task automatic hang(input string name);
    errors++;
    $display("[ERR] %s expected done seen timeout", name);
    close_out();
  endtask

  // The request is held until waitrequest is low at a rising edge; one idle cycle follows.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int i;
    @(posedge CLK);
    AVS_ADDRESS    <= a;
    AVS_WRITEDATA  <= d;
    AVS_BYTEENABLE <= be;
    AVS_WRITE      <= wr;
    AVS_READ       <= ~wr;
    for (i = 0; i < 16; i++) begin
      @(posedge CLK);
      if (AVS_WAITREQUEST === 1'b0) break;
    end
    if (i == 16) hang("waitrequest");
    rd = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ  <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(name, {32'h0, exp}, {32'h0, rd});
  endtask

  // The link is dropped before every pattern change.
  task automatic set_sel(input logic [3:0] s);
    @(posedge CLK);
    LINK_INIT_DONE <= 1'b0;
    bus(1'b1, tpg_pkg::OFS_CTRL, {28'h0, s}, 4'hf);
  endtask

  task automatic wait_en(input string name, input logic [7:0] exp);
    int i;
    for (i = 0; i < 12; i++) begin
      @(negedge CLK);
      if (LANE_ENABLE === exp) break;
    end
    chk(name, {56'h0, exp}, {56'h0, LANE_ENABLE});
    if (i == 12) hang(name);
  endtask

  // Expected short-frame octet i of lane k; link mode 1 shares the mode 0 layout.
  function automatic logic [7:0] st_oct(input int m, input int k, input int i);
    logic [63:0] f;
    logic [3:0]  kn;
    logic [3:0]  up;
    kn = 4'(k);
    up = (m == 3) ? 4'h3 - kn : 4'hf - kn;
    f = 64'h0;
    if (m == 2) f[63:56] = {kn, 4'h1};
    else for (int j = 0; j < ((m == 3) ? 4 : 5); j++) f[63 - 12 * j -: 12] = {up, kn, 4'(j + 1)};
    return f[63 - 8 * i -: 8];
  endfunction

  task automatic t_regs();
    rd_chk("ctrl reset", tpg_pkg::OFS_CTRL, 32'h0);
    rd_chk("chan reset", tpg_pkg::OFS_CHAN, 32'h3);
    rd_chk("status reset", tpg_pkg::OFS_STATUS, 32'h3fc);
    bus(1'b1, tpg_pkg::OFS_CHAN, 32'h0, 4'he);
    rd_chk("chan masked", tpg_pkg::OFS_CHAN, 32'h3);
  endtask

  task automatic t_power();
    bus(1'b1, tpg_pkg::OFS_LINK, 32'h3, 4'hf);
    bus(1'b1, tpg_pkg::OFS_CHAN, 32'h1, 4'hf);
    wait_en("mode 3 pair 0", 8'h0f);
    bus(1'b1, tpg_pkg::OFS_LINK, 32'h0, 4'hf);
    bus(1'b1, tpg_pkg::OFS_CHAN, 32'h2, 4'hf);
    wait_en("pair 1 only", 8'hf0);
    bus(1'b1, tpg_pkg::OFS_CHAN, 32'h3, 4'hf);
    set_sel(4'h6);
    @(posedge CLK);
    POWER_DOWN_PIN <= 1'b1;
    wait_en("pin down", 8'h00);
    rd_chk("status down", tpg_pkg::OFS_STATUS, 32'h1);
    rd_chk("ctrl kept", tpg_pkg::OFS_CTRL, 32'h6);
    rd_chk("chan kept", tpg_pkg::OFS_CHAN, 32'h3);
    @(posedge CLK);
    POWER_DOWN_PIN <= 1'b0;
    wait_en("pin up", 8'hff);
    bus(1'b1, tpg_pkg::OFS_CTRL, 32'h16, 4'hf);
    wait_en("soft down", 8'h00);
  endtask

  task automatic t_clock();
    logic [63:0] a;
    set_sel(4'h6);
    repeat (3) @(negedge CLK);
    a = LANE_DATA;
    @(negedge CLK);
    chk("clock halves", {64{1'b1}}, a ^ LANE_DATA);
    chk("clock octets", 64'h1, {63'h0, a === '1 || a === '0});
    chk("clock layers", 64'h3, {62'h0, LINK_BYPASS, TRANSPORT_OFF});
  endtask

  task automatic t_prbs();
    logic [4:0]  ta[5] = '{5'd6, 5'd5, 5'd14, 5'd18, 5'd28};
    logic [4:0]  tb[5] = '{5'd7, 5'd9, 5'd15, 5'd23, 5'd31};
    logic [15:0] g;
    logic [63:0] a;
    logic        dif;
    for (int s = 0; s < 5; s++) begin
      set_sel(4'(s + 1));
      g = good_bits;
      tap_a <= ta[s];
      tap_b <= tb[s];
      check_en <= 1'b1;
      dif = 1'b0;
      repeat (64) begin
        @(negedge CLK);
        dif |= (LANE_DATA[7:0] !== LANE_DATA[15:8]);
      end
      a = LANE_DATA;
      if (s < 2) begin
        repeat ((s == 0) ? 127 : 511) @(negedge CLK);
        chk("prbs period", a, LANE_DATA);
      end
      check_en <= 1'b0;
      chk("prbs recurrence", 64'h0, {48'h0, bad_bits});
      chk("prbs checked", 64'h1, {63'h0, good_bits > g + 16'd200});
      chk("prbs lanes differ", 64'h1, {63'h0, dif});
      chk("prbs layers", 64'h3, {62'h0, LINK_BYPASS, TRANSPORT_OFF});
    end
  endtask

  task automatic t_ramp();
    logic [7:0] p;
    logic [7:0] c;
    logic       go;
    logic       bad;
    logic       wrap;
    set_sel(4'h7);
    repeat (4) @(negedge CLK);
    chk("ramp held", 64'h0, LANE_DATA);
    chk("ramp layers", 64'h1, {62'h0, LINK_BYPASS, TRANSPORT_OFF});
    @(posedge CLK);
    LINK_INIT_DONE <= 1'b1;
    {go, bad, wrap, p} = 11'h0;
    repeat (300) begin
      @(negedge CLK);
      c = LANE_DATA[7:0];
      bad |= (LANE_DATA !== {8{c}}) || (go && c !== p + 8'h1);
      wrap |= (p == 8'hff) && (c == 8'h0);
      go |= (c !== p);
      p = c;
    end
    chk("ramp steps", 64'h0, {63'h0, bad});
    chk("ramp start wrap", 64'h3, {62'h0, go, wrap});
    rd_chk("status ramp", tpg_pkg::OFS_STATUS, 32'h3fe);
  endtask

  task automatic t_short();
    logic [63:0] e;
    logic [63:0] mk;
    logic [7:0]  le;
    int          len;
    int          i;
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, tpg_pkg::OFS_LINK, 32'(m), 4'hf);
      set_sel(4'h8);
      len = (m == 2) ? 1 : (m == 3) ? 6 : 8;
      le = 8'hff >> ((m == 0) ? 0 : (m == 1) ? 2 : 4);
      for (int k = 0; k < 8; k++) mk[8 * k +: 8] = {8{le[k]}};
      wait_en("short lanes", le);
      for (i = 0; i < 20 && LANE_DATA[7:0] !== st_oct(m, 0, len - 1); i++) @(negedge CLK);
      if (i == 20) hang("short frame start");
      for (i = 0; i < 2 * len; i++) begin
        @(negedge CLK);
        for (int k = 0; k < 8; k++) e[8 * k +: 8] = le[k] ? st_oct(m, k, i % len) : 8'h0;
        chk("short frame", e, LANE_DATA & mk);
      end
    end
    bus(1'b1, tpg_pkg::OFS_LINK, 32'h0, 4'hf);
    SAMPLE_DATA <= 64'h0123_4567_89ab_cdef;
    set_sel(4'h9);
    repeat (3) @(negedge CLK);
    chk("no long pattern", SAMPLE_DATA, LANE_DATA);
  endtask

  initial begin
    repeat (6) @(posedge CLK);
    RESETN <= 1'b1;
    repeat (3) @(posedge CLK);
    t_regs();
    t_power();
    t_clock();
    t_prbs();
    t_ramp();
    t_short();
    close_out();
  end
endmodule
